// ---- include/fsw_defs.vh ----
// Constants for the flash status register and write-enable logic
// Contract
// - Register read repeats value until chip select high
// - Status byte layout lock,quad,protect,latch,busy
// - Busy reads 1 during internal write cycle
// - Latch bit reads 1 when write enabled
// - Protect bits 2..5 writable, nonvolatile
// - Bit 6 enables quad data function
// - Bit 7 marks status register locked
// - Status write never changes the latch
// - Status write updates protect, quad, lock bits
// - Busy read-only, set for whole operation
// - While busy only reads, resets, suspend accepted
// - Busy clears on completion, pass or fail
// - Latch zero inhibits all gated instructions
// - Write enable 06h sets the latch
// - Write disable or op completion clears latch
// - Page program opcodes are latch gated
// - Erase opcodes are latch gated
// - Register write opcodes are latch gated
// - Info row, boot, bank writes latch gated
// - Sector protection opcodes are latch gated
// - Gang, password, training writes latch gated
// - Volatile parameter and bank writes need no latch; code frees only c0h and 17h, while 63h and c5h still need the latch
// - Chip erase ignored unless protect bits zero
// - Lock bit with pin low blocks status writes
`ifndef FSW_DEFS_VH
`define FSW_DEFS_VH

// ==========================================================
// Status byte fields
`define FSW_BIT_BUSY      0
`define FSW_BIT_LATCH     1
`define FSW_PROT_LO       2
`define FSW_PROT_HI       5
`define FSW_BIT_QUAD      6
`define FSW_BIT_LOCK      7
`define FSW_STATUS_RESET  8'h00
`define FSW_PROT_NONE     4'h0

// ==========================================================
// Opcodes
`define FSW_OP_WRITE_ENABLE  8'h06
`define FSW_OP_WRITE_DISABLE 8'h04
`define FSW_OP_RDSR          8'h05
`define FSW_OP_RDERP         8'h81
`define FSW_OP_SUSPEND       8'h75
`define FSW_OP_SWRESET       8'h99
`define FSW_OP_STATUS_WRITE  8'h01
`define FSW_OP_ARRAY_ERASE_A 8'hc7
`define FSW_OP_ARRAY_ERASE_B 8'h60
`define FSW_OP_VOL_PARAM     8'h63
`define FSW_OP_VOL_PARAM_ALT 8'hc0
`define FSW_OP_VOL_BANK      8'hc5
`define FSW_OP_VOL_BANK_ALT  8'h17

// ==========================================================
// Front-end states
`define FSW_ST_OPCODE     2'h0
`define FSW_ST_DATA       2'h1
`define FSW_ST_READ       2'h2
`define FSW_ST_IGNORE     2'h3

`endif

// ---- design/fsw_gate_decode.v ----
// Opcode classifier for latch-gated instructions
`include "fsw_defs.vh"

module fsw_gate_decode (
  // Opcode in
  input  wire [7:0] opcode,
  // Class out
  output reg        isGated,
  output reg        isVolatileFree
);

  always @* begin
    isGated        = 1'b0;
    isVolatileFree = 1'b0;
    case (opcode)
      8'h02, 8'h12, 8'h32, 8'h34, 8'h38, 8'h3e: isGated = 1'b1;
      8'hd7, 8'h20, 8'h21, 8'h52, 8'h5c, 8'hd8, 8'hdc,
      8'hc7, 8'h60: isGated = 1'b1;
      8'h01, 8'h42, 8'h65, 8'h85, 8'h83: isGated = 1'b1;
      8'h64, 8'h62, 8'h15, 8'h18: isGated = 1'b1;
      8'hfb, 8'he1, 8'hfd, 8'he3, 8'he4, 8'h2f, 8'ha6, 8'h91: isGated = 1'b1;
      8'h7e, 8'h98, 8'he8, 8'h43, 8'h4a: isGated = 1'b1;
      // Volatile writes: main codes need the latch, alternates do not
      `FSW_OP_VOL_PARAM, `FSW_OP_VOL_BANK: begin
        isGated        = 1'b1;
        isVolatileFree = 1'b1;
      end
      `FSW_OP_VOL_PARAM_ALT, `FSW_OP_VOL_BANK_ALT:
        isVolatileFree = 1'b1;
      default: isGated = 1'b0;
    endcase
  end

endmodule

// ---- design/fsw_status_logic.v ----
// Status register, write-enable latch and busy gating of a serial flash
`include "fsw_defs.vh"

module fsw_status_logic (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Host serial frame, bytewise
  input  wire       csActive,
  input  wire       byteValid,
  input  wire [7:0] byteIn,
  input  wire       byteTake,
  input  wire       hwResetReq,
  // Write-protect pin, low protects
  input  wire       writeProtectN,
  // Internal engine
  input  wire       opDone,
  input  wire       opIsProgErase,
  // Outputs
  output reg  [7:0] dataOut,
  output reg        dataOutValid,
  output reg  [7:0] deviceStatusByte,
  output reg        opStart,
  output reg  [7:0] opCode,
  output reg        suspendReq,
  output reg        quadEnabled
);

  // ==========================================================
  // State
  reg  [1:0] state;
  reg        busyFlag;
  reg        writeEnableLatch;
  reg  [3:0] protectLevel;
  reg        quadIoEnable;
  reg        statusLockBit;
  reg        busyProgErase;
  reg  [7:0] curOp;

  wire       isGated;
  wire       isVolatileFree;

  fsw_gate_decode uDecode (
    .opcode         (byteIn),
    .isGated        (isGated),
    .isVolatileFree (isVolatileFree)
  );

  wire [7:0] statusView = {statusLockBit, quadIoEnable, protectLevel,
                           writeEnableLatch, busyFlag};

  function isStatusRead;
    input [7:0] op;
    begin
      isStatusRead = (op == `FSW_OP_RDSR) || (op == `FSW_OP_RDERP);
    end
  endfunction

  function isChipErase;
    input [7:0] op;
    begin
      isChipErase = (op == `FSW_OP_ARRAY_ERASE_A) || (op == `FSW_OP_ARRAY_ERASE_B);
    end
  endfunction

  wire firstByte = csActive && byteValid && (state == `FSW_ST_OPCODE);
  // Busy filter: reads, reset, suspend only
  wire allowedBusy = isStatusRead(byteIn) || (byteIn == `FSW_OP_SWRESET) ||
                     ((byteIn == `FSW_OP_SUSPEND) && busyProgErase);
  wire accept = !busyFlag || allowedBusy;
  // Gated opcode needs latch; chip erase needs no protected blocks
  wire gateOk = !isGated || writeEnableLatch;
  wire ceOk = !isChipErase(byteIn) || (protectLevel == `FSW_PROT_NONE);
  // Status write locked by bit 7 and pin low
  wire srLocked = statusLockBit && !writeProtectN;
  wire swReset = firstByte && (byteIn == `FSW_OP_SWRESET);

  // ==========================================================
  // Front-end and register updates
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state            <= `FSW_ST_OPCODE;
      busyFlag         <= 1'b0;
      writeEnableLatch <= 1'b0;
      protectLevel     <= 4'h0;
      quadIoEnable     <= 1'b0;
      statusLockBit    <= 1'b0;
      busyProgErase    <= 1'b0;
      curOp            <= 8'h00;
      opStart          <= 1'b0;
      opCode           <= 8'h00;
      suspendReq       <= 1'b0;
    end else begin
      opStart    <= 1'b0;
      suspendReq <= 1'b0;
      if (opDone && busyFlag) begin
        busyFlag         <= 1'b0;
        busyProgErase    <= 1'b0;
        writeEnableLatch <= 1'b0;
      end
      if (hwResetReq || swReset) begin
        // Reset aborts volatile state only; nonvolatile bits survive
        state            <= `FSW_ST_IGNORE;
        busyFlag         <= 1'b0;
        busyProgErase    <= 1'b0;
        writeEnableLatch <= 1'b0;
      end else if (!csActive) begin
        state <= `FSW_ST_OPCODE;
      end else if (byteValid) begin
        case (state)
          `FSW_ST_OPCODE: begin
            curOp <= byteIn;
            if (!accept) begin
              state <= `FSW_ST_IGNORE;
            end else if (isStatusRead(byteIn)) begin
              state <= `FSW_ST_READ;
            end else if (byteIn == `FSW_OP_SUSPEND) begin
              suspendReq <= 1'b1;
              state      <= `FSW_ST_IGNORE;
            end else if (byteIn == `FSW_OP_WRITE_ENABLE) begin
              writeEnableLatch <= 1'b1;
              state            <= `FSW_ST_IGNORE;
            end else if (byteIn == `FSW_OP_WRITE_DISABLE) begin
              writeEnableLatch <= 1'b0;
              state            <= `FSW_ST_IGNORE;
            end else if (!gateOk || !ceOk) begin
              state <= `FSW_ST_IGNORE;
            end else if (byteIn == `FSW_OP_STATUS_WRITE) begin
              state <= srLocked ? `FSW_ST_IGNORE : `FSW_ST_DATA;
            end else if (isGated || isVolatileFree) begin
              // Engine takes the rest of the frame itself
              opStart <= 1'b1;
              opCode  <= byteIn;
              // Volatile writes run no internal cycle, so no busy
              if (isGated && !isVolatileFree) begin
                busyFlag      <= 1'b1;
                busyProgErase <= !isVolatileFree && opIsProgErase;
              end
              state <= `FSW_ST_IGNORE;
            end else begin
              state <= `FSW_ST_IGNORE;
            end
          end
          `FSW_ST_DATA: begin
            // Latch left alone here; it clears at completion
            statusLockBit <= byteIn[`FSW_BIT_LOCK];
            quadIoEnable  <= byteIn[`FSW_BIT_QUAD];
            protectLevel  <= byteIn[`FSW_PROT_HI:`FSW_PROT_LO];
            busyFlag      <= 1'b1;
            opStart       <= 1'b1;
            opCode        <= curOp;
            state         <= `FSW_ST_IGNORE;
          end
          `FSW_ST_READ: state <= `FSW_ST_READ;
          default:      state <= `FSW_ST_IGNORE;
        endcase
      end
    end
  end

  // ==========================================================
  // Read path, live status byte re-sampled on each taken byte while chip select holds
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dataOut          <= 8'h00;
      dataOutValid     <= 1'b0;
      deviceStatusByte <= `FSW_STATUS_RESET;
      quadEnabled      <= 1'b0;
    end else begin
      deviceStatusByte <= statusView;
      quadEnabled      <= quadIoEnable;
      dataOutValid     <= csActive && (state == `FSW_ST_READ);
      if (csActive && (state == `FSW_ST_READ) && byteTake) begin
        dataOut <= statusView;
      end else if (!csActive) begin
        dataOut <= 8'h00;
      end
    end
  end

endmodule

// ---- verification/fsw_status_logic_monitor.sv ----
// Assertion checker for the status and write-enable logic
module fsw_status_logic_monitor (
  // Clock, reset and host frame
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       csActive,
  input wire logic       byteValid,
  input wire logic [7:0] byteIn,
  input wire logic       byteTake,
  // Pin, engine and outputs
  input wire logic       writeProtectN,
  input wire logic       opDone,
  input wire logic       opIsProgErase,
  input wire logic [7:0] dataOut,
  input wire logic       dataOutValid,
  input wire logic [7:0] deviceStatusByte,
  input wire logic       opStart,
  input wire logic       suspendReq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Opcode position tracking
  logic            inFrame;
  wire logic [7:0] sb = deviceStatusByte;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) inFrame <= 1'b0;
    else inFrame <= csActive & (inFrame | byteValid);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_op(logic [7:0] c);
    csActive && byteValid && !inFrame && byteIn == c;
  endsequence
  // Status byte lags one cycle, so a just-finished op is excluded
  sequence s_busyOp(logic [7:0] c);
    s_op(c) ##0 sb[0] && !$past(opDone) && !opDone;
  endsequence
  // ==========
  // Properties
  property p_write_enable_cmd; s_op(8'h06) ##0 !sb[0] |-> ##2 sb[1]; endproperty
  a_write_enable_cmd: assert property (p_write_enable_cmd) else $error("latch not set");
  property p_gated; s_op(8'h02) ##0 !sb[1] |=> !opStart [*3]; endproperty
  a_gated: assert property (p_gated) else $error("gated op ran");
  property p_done; opDone && sb[0] |-> ##[1:2] !sb[0] && !sb[1]; endproperty
  a_done: assert property (p_done) else $error("busy or latch kept");
  property p_busy; s_busyOp(8'h04) ##1 !opDone |=> sb[1]; endproperty
  a_busy: assert property (p_busy) else $error("op taken while busy");
  property p_susp; s_busyOp(8'h75) ##0 opIsProgErase |=> suspendReq; endproperty
  a_susp: assert property (p_susp) else $error("suspend lost");
  property p_chip; s_op(8'hc7) ##0 sb[5:2] != 4'h0 |=> !opStart [*3]; endproperty
  a_chip: assert property (p_chip) else $error("erase ran");
  property p_lock; s_op(8'h01) ##0 sb[7] && !writeProtectN |=> !opStart [*3]; endproperty
  a_lock: assert property (p_lock) else $error("locked write ran");
  property p_rep; byteTake && dataOutValid ##1 $stable(sb) |-> dataOut == sb; endproperty
  a_rep: assert property (p_rep) else $error("read byte wrong");
endmodule

bind fsw_status_logic fsw_status_logic_monitor mon (.*);

// ---- verification/fsw_host_model.sv ----
// Host frame driver facing the status logic
module fsw_host_model (
  // Clock and read data
  input  wire logic       clk,
  input  wire logic [7:0] dataOut,
  input  wire logic       dataOutValid,
  // Frame lines
  output logic            csActive  = 1'b0,
  output logic            byteValid = 1'b0,
  output logic [7:0]      byteIn    = 8'h00,
  output logic            byteTake  = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Opcode and optional data byte, select drops after
  task automatic frame(input logic [7:0] op, input logic [7:0] dat, input bit hasDat);
    @(posedge clk);
    csActive  <= 1'b1;
    byteValid <= 1'b1;
    byteIn    <= op;
    @(posedge clk);
    byteValid <= hasDat;
    byteIn    <= dat;
    @(posedge clk);
    csActive  <= 1'b0;
    byteValid <= 1'b0;
    byteIn    <= ~dat;
  endtask
  // Status read, select held open across four taken bytes, two of them sampled
  task automatic read(output logic [7:0] a, output logic [7:0] b, output logic v);
    @(posedge clk);
    csActive  <= 1'b1;
    byteValid <= 1'b1;
    byteIn    <= 8'h05;
    @(posedge clk);
    byteValid <= 1'b0;
    byteTake  <= 1'b1;
    repeat (2) @(posedge clk);
    #1 a = dataOut;
    v = dataOutValid;
    @(posedge clk);
    #1 b = dataOut;
    @(posedge clk);
    byteTake <= 1'b0;
    csActive <= 1'b0;
  endtask
endmodule

// ---- verification/fsw_status_logic_tb.sv ----
// Self-checking bench for the status and write-enable logic
module fsw_status_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, wpN = 1'b1, opDone = 1'b0, progErase = 1'b0, hwRst = 1'b0;
  wire logic cs, bv, bt, dv, start, susp, quad;
  wire logic [7:0] bi, dOut, sb, code;
  int failCount = 0, nChecks = 0, starts = 0, susps = 0, s;
  logic [7:0] a, b;
  logic v;
  logic [7:0] gated [39] = '{8'h02, 8'h12, 8'h32, 8'h34, 8'h38, 8'h3e, 8'hd7, 8'h20,
    8'h21, 8'h52, 8'h5c, 8'hd8, 8'hdc, 8'hc7, 8'h60, 8'h01, 8'h42, 8'h65, 8'h85, 8'h83,
    8'h63, 8'h64, 8'h62, 8'h15, 8'h18, 8'hc5, 8'hfb, 8'he1, 8'hfd, 8'he3, 8'he4, 8'h2f,
    8'ha6, 8'h91, 8'h7e, 8'h98, 8'he8, 8'h43, 8'h4a};
  always #2 clk = ~clk;
  always @(posedge clk) begin
    starts += (start === 1'b1);
    susps += (susp === 1'b1);
  end
  fsw_host_model host (.clk(clk), .dataOut(dOut), .dataOutValid(dv), .csActive(cs),
    .byteValid(bv), .byteIn(bi), .byteTake(bt));
  fsw_status_logic uut (.clk(clk), .rst(rst), .csActive(cs), .byteValid(bv), .byteIn(bi),
    .byteTake(bt), .hwResetReq(hwRst), .writeProtectN(wpN), .opDone(opDone),
    .opIsProgErase(progErase), .dataOut(dOut), .dataOutValid(dv), .deviceStatusByte(sb),
    .opStart(start), .opCode(code), .suspendReq(susp), .quadEnabled(quad));
  // ==========
  // Shared tasks
  task chk(string nm, logic [7:0] got, logic [7:0] exp);
    nChecks++;
    if (got !== exp) begin
      failCount++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask
  task endSim();
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task w(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task op(logic [7:0] c, logic [7:0] d);
    host.frame(c, d, 1'b1);
    w(2);
  endtask
  task done();
    @(posedge clk);
    opDone <= 1'b1;
    @(posedge clk);
    opDone <= 1'b0;
    w(3);
  endtask
  // ==========
  // Scenarios
  task tGated();
    s = starts;
    chk("reset status", sb, 8'h00);
    foreach (gated[i]) begin
      op(gated[i], 8'h3c);
      chk("refused status", sb, 8'h00);
    end
    chk("refused starts", 8'(starts - s), 8'h00);
    $display("tGated finished");
  endtask
  task tStatus();
    s = starts;
    op(8'h06, 8'h00);
    chk("latch set", sb, 8'h02);
    op(8'h01, 8'hff);
    chk("write started", 8'(starts - s), 8'h01);
    chk("launched code", code, 8'h01);
    chk("busy and latch", sb & 8'h03, 8'h03);
    op(8'h04, 8'h00);
    chk("disable ignored", sb & 8'h03, 8'h03);
    host.read(a, b, v);
    chk("read busy", a, 8'hff);
    chk("read repeat", b, 8'hff);
    chk("read valid", {7'h00, v}, 8'h01);
    done();
    chk("stored bits", sb, 8'hfc);
    chk("quad", {7'h00, quad}, 8'h01);
    chk("valid idle", {7'h00, dv}, 8'h00);
    $display("tStatus finished");
  endtask
  task tLock();
    @(posedge clk);
    wpN <= 1'b0;
    op(8'h06, 8'h00);
    s = starts;
    op(8'h01, 8'h00);
    op(8'hc7, 8'h00);
    chk("locked starts", 8'(starts - s), 8'h00);
    chk("locked status", sb, 8'hfe);
    op(8'h04, 8'h00);
    chk("latch cleared", sb, 8'hfc);
    @(posedge clk);
    wpN <= 1'b1;
    op(8'h06, 8'h00);
    op(8'h01, 8'h00);
    chk("unlocked start", 8'(starts - s), 8'h01);
    done();
    chk("cleared status", sb, 8'h00);
    $display("tLock finished");
  endtask
  task tSuspend();
    @(posedge clk);
    progErase <= 1'b1;
    op(8'h06, 8'h00);
    op(8'h02, 8'h00);
    chk("program code", code, 8'h02);
    s = susps;
    op(8'h75, 8'h00);
    chk("suspend", 8'(susps - s), 8'h01);
    op(8'h99, 8'h00);
    chk("soft reset", sb, 8'h00);
    s = starts;
    op(8'hc0, 8'h00);
    chk("volatile start", 8'(starts - s), 8'h01);
    chk("volatile code", code, 8'hc0);
    chk("volatile status", sb, 8'h00);
    $display("tSuspend finished");
  endtask
  task tHwReset();
    op(8'h06, 8'h00);
    op(8'h01, 8'h40);
    chk("write busy", sb & 8'h03, 8'h03);
    @(posedge clk);
    hwRst <= 1'b1;
    @(posedge clk);
    hwRst <= 1'b0;
    w(2);
    chk("hard reset", sb, 8'h40);
    chk("quad kept", {7'h00, quad}, 8'h01);
    $display("tHwReset finished");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    w(1);
    tGated();
    tStatus();
    tLock();
    tSuspend();
    tHwReset();
    endSim();
  end
  initial begin
    repeat (3000) @(posedge clk);
    failCount++;
    endSim();
  end
endmodule
